// ===== src/rx_config_pkg.sv
// shared constants for the receiver configuration register bank
package rx_config_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_FRAME_DETECT = 8'h34;
    localparam logic [7:0] IDX_CONTROL      = 8'h35;
    localparam logic [7:0] IDX_WAIT_TIME    = 8'h36;
    localparam logic [7:0] IDX_THRESHOLD    = 8'h37;
    // frame detect status fields
    localparam int SOF_IRQ_EN_BIT  = 5;
    localparam int SOF_SEEN_BIT    = 4;
    localparam int SUBC_IRQ_EN_BIT = 2;
    localparam int SUBC_SEEN_BIT   = 1;
    localparam int SUBC_LIVE_BIT   = 0;
    // receive control fields
    localparam int ALLOW_PARTIAL_BIT = 7;
    localparam int MULTI_FRAME_BIT   = 6;
    localparam int EOF_TYPE_BIT      = 5;
    localparam int GUARD_CHECK_BIT   = 4;
    localparam int DISTURB_SUP_BIT   = 3;
    localparam int BAUD_LSB          = 0;
    localparam int BAUD_W            = 3;
    // wait time fields
    localparam int WAIT_UNIT_BIT = 7;
    localparam int WAIT_COUNT_W  = 7;
    // threshold fields
    localparam int DECODER_LVL_LSB = 4;
    localparam int PHASE_LVL_LSB   = 0;
    localparam int LEVEL_W         = 4;
    // writable masks; reserved bits stay zero
    localparam logic [7:0] FRAME_DETECT_WMASK = 8'h24;
    localparam logic [7:0] FRAME_DETECT_CMASK = 8'h12;
    // reset values
    localparam logic [7:0] CONTROL_RESET   = 8'h04;
    localparam logic [7:0] WAIT_RESET      = 8'h00;
    localparam logic [7:0] THRESHOLD_RESET = 8'h00;
    // baud codes
    localparam logic [2:0] BAUD_26K  = 3'h2;
    localparam logic [2:0] BAUD_52K  = 3'h3;
    localparam logic [2:0] BAUD_106K = 3'h4;
    localparam logic [2:0] BAUD_212K = 3'h5;
    localparam logic [2:0] BAUD_424K = 3'h6;
    localparam logic [2:0] BAUD_847K = 3'h7;
    // disturbance window in bytes
    localparam int EMD_BYTES = 3;
    // wait unit: 16 carrier cycles at 13.56 MHz, clock 40 MHz
    localparam int CARRIER_KHZ      = 13560;
    localparam int CLK_KHZ          = 40000;
    localparam int UNIT_CARRIER_CYC = 16;
    localparam int UNIT_CLKS = (UNIT_CARRIER_CYC * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;
    localparam int UNIT_CNT_W = 6;
endpackage : rx_config_pkg

// ===== src/rx_config_regs.sv
// receiver configuration and status register bank with its frame-level control
// Operation
// [R1] frame start with enable raises start interrupt
// [R2] sticky frame-start flag until software clears
// [R3] subcarrier with enable raises same interrupt
// [R4] sticky subcarrier flag until software clears
// [R5] live subcarrier bit, read only, unlatched
// [R6] allow partial: store incomplete byte despite checksum
// [R7] multi-frame: receiver keeps running after frame
// [R8] multi-frame: append error register copy per frame
// [R9] end type bit picks symbol or type-B end
// [R10] no end check when type and symbols clear
// [R11] guard check: overlong guard time flags protocol error
// [R12] suppression: error in three bytes discards, resets
// [R13] collision counts as error during suppression
// [R14] discarded reception gives no complete interrupt
// [R15] host waits three bytes before reading store
// [R16] three-bit baud field selects receive rate
// [R17] wait unit: 16 carrier cycles or half bit
// [R18] input ignored for programmed wait after sending
// [R19] upper nibble sets decoder minimum level
// [R20] lower nibble sets phase detector minimum level
// [R21] half-bit tick comes from transmit bit rate
// [R22] reserved bits read zero, writes ignored
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/10ps
module rx_config_regs #(
    parameter int ADR_W = 10
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // wishbone classic slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADR_W-1:0]  adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // receive path events
    input  wire logic              sof_detect,
    input  wire logic              subcarrier_detect,
    input  wire logic              tx_done,
    input  wire logic              bit_half_tick,
    input  wire logic              rx_byte_valid,
    input  wire logic [7:0]        rx_byte,
    input  wire logic              rx_byte_partial,
    input  wire logic              crc_enable,
    input  wire logic              rx_error,
    input  wire logic              rx_collision,
    input  wire logic              rx_frame_end,
    input  wire logic              type_b_mode,
    input  wire logic              guard_time_long,
    input  wire logic [7:0]        error_status,
    input  wire logic [1:0]        frame_end_symbol_setting,
    // outputs toward the receive path
    output logic                   receive_frame_start_interrupt,
    output logic                   receive_ignore,
    output logic                   fifo_write,
    output logic      [7:0]        fifo_data,
    output logic                   fifo_clear,
    output logic                   rx_complete,
    output logic                   rx_stop,
    output logic                   protocol_error,
    output logic                   frame_end_check_enable,
    output logic                   frame_end_type_select,
    output logic      [2:0]        receive_baud,
    output logic      [3:0]        decoder_min_threshold,
    output logic      [3:0]        phase_detector_threshold
);
    initial begin
        if (ADR_W < 10) $error("ADR_W must reach index 37h");
    end

    // register contents
    logic [7:0] frame_detect;      // enables and sticky flags
    logic [7:0] receive_control;   // receive options and baud
    logic [7:0] receive_wait_time; // wait unit and count
    logic [7:0] receive_threshold; // decoder and phase detector levels

    // bus decode: one access ends per ack
    logic       bus_req;
    logic       wr_strobe;
    logic [7:0] word_idx;
    assign bus_req   = cyc_i && stb_i && !ack_o;
    assign wr_strobe = bus_req && we_i && sel_i[0];
    assign word_idx  = adr_i[9:2];

    // ack one cycle after the request, dropped the next cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req;
        end
    end

    // read mux; unmapped words answer zero
    logic [7:0] read_byte;
    always_comb begin
        unique case (word_idx)
            rx_config_pkg::IDX_FRAME_DETECT: read_byte = {frame_detect[7:1], subcarrier_detect}; // see [R5]
            rx_config_pkg::IDX_CONTROL:      read_byte = receive_control;
            rx_config_pkg::IDX_WAIT_TIME:    read_byte = receive_wait_time;
            rx_config_pkg::IDX_THRESHOLD:    read_byte = receive_threshold;
            default:                         read_byte = 8'h00;
        endcase
    end

    // read data captured with the ack
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dat_o <= 32'h00000000;
        end else if (bus_req && !we_i) begin
            dat_o <= {24'h000000, read_byte};
        end
    end

    // input gating while the post-send wait runs
    logic sof_ev;
    logic subc_ev;
    assign sof_ev  = sof_detect && !receive_ignore;        // see [R18]
    assign subc_ev = subcarrier_detect && !receive_ignore; // see [R18]

    // frame detect: enables written, flags set by hardware, write one clears
    logic       wr_detect;
    logic [7:0] clear_bits;
    logic [7:0] set_bits;
    assign wr_detect  = wr_strobe && word_idx == rx_config_pkg::IDX_FRAME_DETECT;
    assign clear_bits = wr_detect ? (dat_i[7:0] & rx_config_pkg::FRAME_DETECT_CMASK) : 8'h00;
    assign set_bits   = {3'h0, sof_ev, 2'h0, subc_ev, 1'b0};
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            frame_detect <= 8'h00;
        end else begin
            // set wins over a clear in the same cycle
            frame_detect[rx_config_pkg::SOF_SEEN_BIT]  <= set_bits[rx_config_pkg::SOF_SEEN_BIT]  // see [R2]
                || (frame_detect[rx_config_pkg::SOF_SEEN_BIT] && !clear_bits[rx_config_pkg::SOF_SEEN_BIT]);
            frame_detect[rx_config_pkg::SUBC_SEEN_BIT] <= set_bits[rx_config_pkg::SUBC_SEEN_BIT] // see [R4]
                || (frame_detect[rx_config_pkg::SUBC_SEEN_BIT] && !clear_bits[rx_config_pkg::SUBC_SEEN_BIT]);
            if (wr_detect) begin
                frame_detect[rx_config_pkg::SOF_IRQ_EN_BIT]  <= dat_i[rx_config_pkg::SOF_IRQ_EN_BIT];
                frame_detect[rx_config_pkg::SUBC_IRQ_EN_BIT] <= dat_i[rx_config_pkg::SUBC_IRQ_EN_BIT];
            end
        end
    end

    // plain configuration registers; every bit is defined here
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            receive_control   <= rx_config_pkg::CONTROL_RESET;
            receive_wait_time <= rx_config_pkg::WAIT_RESET;
            receive_threshold <= rx_config_pkg::THRESHOLD_RESET;
        end else if (wr_strobe) begin
            if (word_idx == rx_config_pkg::IDX_CONTROL) receive_control <= dat_i[7:0];
            if (word_idx == rx_config_pkg::IDX_WAIT_TIME) receive_wait_time <= dat_i[7:0];
            if (word_idx == rx_config_pkg::IDX_THRESHOLD) receive_threshold <= dat_i[7:0];
        end
    end

    // field views
    logic       allow_partial_byte;
    logic       multi_frame_receive;
    logic       guard_time_check;
    logic       disturbance_suppression;
    logic       receive_wait_unit;
    logic [6:0] receive_ignore_count;
    assign allow_partial_byte      = receive_control[rx_config_pkg::ALLOW_PARTIAL_BIT];
    assign multi_frame_receive     = receive_control[rx_config_pkg::MULTI_FRAME_BIT];
    assign guard_time_check        = receive_control[rx_config_pkg::GUARD_CHECK_BIT];
    assign disturbance_suppression = receive_control[rx_config_pkg::DISTURB_SUP_BIT];
    assign receive_wait_unit       = receive_wait_time[rx_config_pkg::WAIT_UNIT_BIT];
    assign receive_ignore_count    = receive_wait_time[6:0];

    // static configuration outputs
    assign frame_end_type_select    = receive_control[rx_config_pkg::EOF_TYPE_BIT];            // see [R9]
    assign frame_end_check_enable   = frame_end_type_select || (frame_end_symbol_setting != 2'h0); // see [R10]
    assign receive_baud             = receive_control[2:0];                                    // see [R16]
    assign decoder_min_threshold    = receive_threshold[7:4];                                  // see [R19]
    assign phase_detector_threshold = receive_threshold[3:0];                                  // see [R20]

    // shared start interrupt, held while an enabled flag stands
    assign receive_frame_start_interrupt =
        (frame_detect[rx_config_pkg::SOF_IRQ_EN_BIT] && frame_detect[rx_config_pkg::SOF_SEEN_BIT])      // see [R1]
        || (frame_detect[rx_config_pkg::SUBC_IRQ_EN_BIT] && frame_detect[rx_config_pkg::SUBC_SEEN_BIT]); // see [R3]

    // wait unit prescaler: carrier-based count or half-bit tick
    logic [rx_config_pkg::UNIT_CNT_W-1:0] unit_cnt;
    logic                                 unit_tick;
    logic [6:0]                           ignore_left;
    assign unit_tick = receive_wait_unit ? bit_half_tick                                  // see [R17] [R21]
        : (unit_cnt == rx_config_pkg::UNIT_CNT_W'(rx_config_pkg::UNIT_CLKS - 1));          // see [R17]
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            unit_cnt <= '0;
        end else if (tx_done || unit_tick) begin
            unit_cnt <= '0;
        end else if (ignore_left != 7'h00) begin
            unit_cnt <= unit_cnt + 1'b1;
        end
    end

    // ignore window loaded at end of sending, counted down in units
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ignore_left <= 7'h00;
        end else if (tx_done) begin
            ignore_left <= receive_ignore_count; // see [R18]
        end else if (unit_tick && ignore_left != 7'h00) begin
            ignore_left <= ignore_left - 1'b1;
        end
    end
    assign receive_ignore = ignore_left != 7'h00; // see [R18]

    // gated receive events
    logic byte_ev;
    logic err_ev;
    logic end_ev;
    logic byte_keep;
    assign byte_ev   = rx_byte_valid && !receive_ignore;
    assign end_ev    = rx_frame_end && !receive_ignore;
    // a collision counts like any error while suppression is on
    assign err_ev    = !receive_ignore && (rx_error || (disturbance_suppression && rx_collision)); // see [R13]
    // an incomplete byte under checksum is kept only when allowed
    assign byte_keep = byte_ev && (!(crc_enable && rx_byte_partial) || allow_partial_byte); // see [R6]

    // byte counter within a frame, saturating at the window size
    logic [1:0] frame_bytes;
    logic       in_window;
    logic       emd_discard;
    logic       end_discard;
    assign in_window   = frame_bytes < 2'(rx_config_pkg::EMD_BYTES);
    assign emd_discard = disturbance_suppression && err_ev && in_window;                     // see [R12]
    assign end_discard = disturbance_suppression && end_ev && in_window && !(byte_keep && frame_bytes == 2'h2); // see [R14]
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            frame_bytes <= 2'h0;
        end else if (emd_discard || end_ev) begin
            frame_bytes <= 2'h0;
        end else if (byte_keep && in_window) begin
            frame_bytes <= frame_bytes + 2'h1;
        end
    end

    // store path: data bytes, and the error copy at a frame end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_write <= 1'b0;
            fifo_data  <= 8'h00;
        end else if (end_ev && multi_frame_receive && !end_discard) begin
            fifo_write <= 1'b1; // see [R8]
            fifo_data  <= error_status;
        end else begin
            fifo_write <= byte_keep && !emd_discard;
            fifo_data  <= byte_keep ? rx_byte : fifo_data;
        end
    end

    // frame outcome pulses
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_clear     <= 1'b0;
            rx_complete    <= 1'b0;
            rx_stop        <= 1'b0;
            protocol_error <= 1'b0;
        end else begin
            fifo_clear     <= emd_discard || end_discard;                       // see [R12]
            rx_complete    <= end_ev && !end_discard;                           // see [R14]
            rx_stop        <= end_ev && !end_discard && !multi_frame_receive;   // see [R7]
            protocol_error <= guard_time_check && type_b_mode && guard_time_long
                              && !receive_ignore;                               // see [R11]
        end
    end

    // checks
    sequence sof_event_s;
        sof_detect && !receive_ignore;
    endsequence
    sof_flag_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [R2]
        sof_event_s |=> frame_detect[rx_config_pkg::SOF_SEEN_BIT])
        else $error("frame start flag not set");
    subc_flag_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [R4]
        frame_detect[rx_config_pkg::SUBC_SEEN_BIT] && !wr_detect |=> frame_detect[rx_config_pkg::SUBC_SEEN_BIT])
        else $error("subcarrier flag dropped without clear");
    start_irq_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [R1]
        sof_event_s ##0 frame_detect[rx_config_pkg::SOF_IRQ_EN_BIT] && !wr_detect |=> receive_frame_start_interrupt)
        else $error("start interrupt missing");
    subc_irq_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [R3]
        !frame_detect[rx_config_pkg::SUBC_IRQ_EN_BIT] && !frame_detect[rx_config_pkg::SOF_IRQ_EN_BIT]
        |-> !receive_frame_start_interrupt)
        else $error("start interrupt without enable");
    ignore_win_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [R18]
        tx_done && receive_ignore_count != 7'h00 && !receive_wait_unit && !wr_strobe
        |=> receive_ignore [*8])
        else $error("ignore window too short");
    stop_multi_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [R7]
        end_ev && multi_frame_receive |=> !rx_stop)
        else $error("receiver stopped in multi-frame mode");
    err_copy_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [R8]
        end_ev && multi_frame_receive && !end_discard |=> fifo_write && fifo_data == $past(error_status))
        else $error("error byte not appended");
    emd_drop_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [R12]
        emd_discard |=> fifo_clear && !fifo_write)
        else $error("disturbance not discarded");
    no_complete_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [R14]
        end_discard |=> !rx_complete ##0 fifo_clear)
        else $error("complete raised on discard");
    partial_drop_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [R6]
        byte_ev && crc_enable && rx_byte_partial && !allow_partial_byte && !end_ev |=> !fifo_write)
        else $error("partial byte stored");
    bus_ack_a: assert property (@(posedge mclk) disable iff (!rst_n)
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack timing wrong");
endmodule : rx_config_regs

// ===== verification/rx_card_model.sv
// behavioural card-side model: frame events, subcarrier level and received bytes
`timescale 1ns/10ps
module rx_card_model (
    input  wire logic       mclk,
    output logic            sof_detect,
    output logic            subcarrier_detect,
    output logic            bit_half_tick,
    output logic            rx_byte_valid,
    output logic [7:0]      rx_byte,
    output logic            rx_byte_partial,
    output logic            rx_error,
    output logic            rx_collision,
    output logic            rx_frame_end,
    output logic            guard_time_long
);
    // quiet field at time zero
    initial begin
        {sof_detect, subcarrier_detect, bit_half_tick, rx_byte_valid, rx_byte_partial} = 5'h00;
        {rx_error, rx_collision, rx_frame_end, guard_time_long} = 4'h0;
        rx_byte = 8'h00;
    end
    // one-cycle event: 0 sof, 1 half-bit tick, 2 error, 3 collision, 4 frame end, 5 guard overrun
    task automatic pulse(input int k);
        {sof_detect, bit_half_tick, rx_error, rx_collision, rx_frame_end, guard_time_long} <= 6'h20 >> k;
        @(posedge mclk);
        {sof_detect, bit_half_tick, rx_error, rx_collision, rx_frame_end, guard_time_long} <= 6'h00;
        @(posedge mclk);
    endtask : pulse
    // one byte; afterwards the data lines show the inverse, never a stale copy
    task automatic send_byte(input logic [7:0] d, input logic part);
        rx_byte_valid <= 1'b1;
        rx_byte <= d;
        rx_byte_partial <= part;
        @(posedge mclk);
        rx_byte_valid <= 1'b0;
        rx_byte <= ~d;
        rx_byte_partial <= ~part;
        @(posedge mclk);
    endtask : send_byte
    // subcarrier level as seen by the demodulator
    task automatic carrier(input logic on);
        subcarrier_detect <= on;
        @(posedge mclk);
    endtask : carrier
endmodule : rx_card_model

// ===== verification/testbench.sv
// self-checking bench for the receiver configuration register bank
`timescale 1ns/10ps
module testbench;
    localparam logic [7:0] FD = rx_config_pkg::IDX_FRAME_DETECT;
    localparam logic [7:0] CT = rx_config_pkg::IDX_CONTROL;
    localparam logic [7:0] WT = rx_config_pkg::IDX_WAIT_TIME;
    localparam logic [7:0] TH = rx_config_pkg::IDX_THRESHOLD;
    localparam int         UC = rx_config_pkg::UNIT_CLKS;
    logic        mclk, rst_n, cyc_i, stb_i, we_i, ack_o, tx_done, crc_enable, type_b_mode;
    logic [9:0]  adr_i;
    logic [3:0]  sel_i, decoder_min_threshold, phase_detector_threshold;
    logic [31:0] dat_i, dat_o;
    logic [7:0]  rx_byte, error_status, fifo_data;
    logic [2:0]  receive_baud;
    logic [1:0]  frame_end_symbol_setting;
    logic        sof_detect, subcarrier_detect, bit_half_tick, rx_byte_valid, rx_byte_partial;
    logic        rx_error, rx_collision, rx_frame_end, guard_time_long, receive_frame_start_interrupt;
    logic        receive_ignore, fifo_write, fifo_clear, rx_complete, rx_stop, protocol_error;
    logic        frame_end_check_enable, frame_end_type_select;
    int          fails, checks_done, ign_cnt;
    logic [7:0]  rdq[$];      // expected read data, bus order
    logic [7:0]  evq[5][$];   // expected pulses per kind: write, clear, complete, stop, protocol error

    rx_config_regs uut (.mclk, .rst_n, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .sof_detect, .subcarrier_detect, .tx_done, .bit_half_tick, .rx_byte_valid, .rx_byte, .rx_byte_partial,
        .crc_enable, .rx_error, .rx_collision, .rx_frame_end, .type_b_mode, .guard_time_long, .error_status,
        .frame_end_symbol_setting, .receive_frame_start_interrupt, .receive_ignore, .fifo_write, .fifo_data,
        .fifo_clear, .rx_complete, .rx_stop, .protocol_error, .frame_end_check_enable, .frame_end_type_select,
        .receive_baud, .decoder_min_threshold, .phase_detector_threshold);
    rx_card_model card (.mclk, .sof_detect, .subcarrier_detect, .bit_half_tick, .rx_byte_valid, .rx_byte,
        .rx_byte_partial, .rx_error, .rx_collision, .rx_frame_end, .guard_time_long);

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input string what, input logic [10:0] e, input logic [10:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    // classic cycle; held until ack is sampled, released at that edge only
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        sel_i <= 4'h1;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'($urandom()), d};
        do @(posedge mclk); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge mclk);
    endtask : wb
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        rdq.push_back(e);
        wb(1'b0, idx, 8'h00);
    endtask : rd
    // n random full bytes, each expected in the store
    task automatic bytes(input int n);
        logic [7:0] d;
        repeat (n) begin
            d = 8'($urandom());
            evq[0].push_back(d);
            card.send_byte(d, 1'b0);
        end
    endtask : bytes
    // read data, bits 10 to 8 must be zero
    always @(posedge mclk) begin
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            if (rdq.size() == 0) chk("unexpected read", 11'h7FF, dat_o[10:0]);
            else chk("read data", {3'h0, rdq.pop_front()}, dat_o[10:0]);
        end
    end
    // receive-path pulses against their own queue
    always @(posedge mclk) begin : pulse_mon
        logic [4:0] o;
        o = {protocol_error, rx_stop, rx_complete, fifo_clear, fifo_write};
        for (int k = 0; k < 5; k++) begin
            if (o[k] === 1'b1 && evq[k].size() == 0) chk("unexpected pulse", 11'h7FF, 11'(k));
            else if (o[k] === 1'b1) chk("pulse", {3'(k), evq[k].pop_front()}, {3'(k), k == 0 ? fifo_data : 8'h00});
        end
    end
    always @(posedge mclk) if (receive_ignore === 1'b1) ign_cnt++;
    // watchdog, far beyond the sequence
    initial begin
        #500000;
        fails++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] r;
        {cyc_i, stb_i, we_i, tx_done, crc_enable, type_b_mode} = 6'h00;
        {adr_i, sel_i, dat_i, error_status, frame_end_symbol_setting} = '0;
        rst_n = 1'b0;
        r = 8'($urandom(32'h86BC675C));
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(FD, 8'h00);
        rd(CT, rx_config_pkg::CONTROL_RESET);
        rd(WT, rx_config_pkg::WAIT_RESET);
        rd(TH, rx_config_pkg::THRESHOLD_RESET);
        wb(1'b1, 8'h40, 8'hFF);
        rd(8'h40, 8'h00);
        r = 8'($urandom());
        wb(1'b1, FD, r);
        rd(FD, r & rx_config_pkg::FRAME_DETECT_WMASK);
        wb(1'b1, FD, 8'h12);
        r = 8'($urandom());
        wb(1'b1, CT, r);
        rd(CT, r);
        chk("end type", {10'h0, r[5]}, {10'h0, frame_end_type_select});
        r = 8'($urandom());
        wb(1'b1, TH, r);
        rd(TH, r);
        chk("decoder level", {7'h0, r[7:4]}, {7'h0, decoder_min_threshold});
        chk("phase level", {7'h0, r[3:0]}, {7'h0, phase_detector_threshold});
        for (int b = 2; b < 8; b++) begin
            wb(1'b1, CT, 8'(b));
            chk("baud", 11'(b), {8'h0, receive_baud});
        end
        wb(1'b1, CT, 8'h04);
        chk("end check off", 11'h0, {10'h0, frame_end_check_enable});
        frame_end_symbol_setting <= 2'h2;
        @(posedge mclk);
        chk("end check sym", 11'h1, {10'h0, frame_end_check_enable});
        frame_end_symbol_setting <= 2'h0;
        wb(1'b1, CT, 8'h24);
        chk("end check b", 11'h1, {10'h0, frame_end_check_enable});
        // start-of-frame flag and interrupt
        wb(1'b1, FD, 8'h20);
        card.pulse(0);
        rd(FD, 8'h30);
        chk("start irq", 11'h1, {10'h0, receive_frame_start_interrupt});
        wb(1'b1, FD, 8'h30);
        rd(FD, 8'h20);
        chk("start irq off", 11'h0, {10'h0, receive_frame_start_interrupt});
        // subcarrier: live bit follows, seen bit sticks
        card.carrier(1'b1);
        wb(1'b1, FD, 8'h04);
        rd(FD, 8'h07);
        chk("subc irq", 11'h1, {10'h0, receive_frame_start_interrupt});
        card.carrier(1'b0);
        rd(FD, 8'h06);
        wb(1'b1, FD, 8'h02);
        rd(FD, 8'h00);
        // plain frame with checksum on; a partial byte is dropped
        crc_enable <= 1'b1;
        wb(1'b1, CT, 8'h04);
        bytes(1);
        card.send_byte(8'h3C, 1'b1);
        evq[2].push_back(8'h00);
        evq[3].push_back(8'h00);
        card.pulse(4);
        wb(1'b1, CT, 8'h84);
        evq[0].push_back(8'hC3);
        card.send_byte(8'hC3, 1'b1);
        // multi-frame: error copy appended, receiver not stopped
        r = 8'($urandom());
        error_status <= r;
        wb(1'b1, CT, 8'h44);
        bytes(2);
        evq[0].push_back(r);
        evq[2].push_back(8'h00);
        card.pulse(4);
        // disturbance suppression; store is not read here before three bytes
        wb(1'b1, CT, 8'h0C);
        bytes(2);
        evq[1].push_back(8'h00);
        card.pulse(2);
        bytes(1);
        evq[1].push_back(8'h00);
        card.pulse(3);
        bytes(2);
        evq[1].push_back(8'h00);
        card.pulse(4);
        bytes(3);
        evq[2].push_back(8'h00);
        evq[3].push_back(8'h00);
        card.pulse(4);
        // guard time overrun in type B
        type_b_mode <= 1'b1;
        wb(1'b1, CT, 8'h14);
        evq[4].push_back(8'h00);
        card.pulse(5);
        wb(1'b1, CT, 8'h04);
        card.pulse(5);
        // ignore window in carrier units; traffic inside it is dropped
        wb(1'b1, WT, 8'h02);
        ign_cnt = 0;
        tx_done <= 1'b1;
        @(posedge mclk);
        tx_done <= 1'b0;
        card.send_byte(8'h99, 1'b0);
        card.pulse(4);
        repeat (2 * UC + 20) @(posedge mclk);
        chk("ignore span", 11'(2 * UC), 11'(ign_cnt));
        // ignore window in half-bit ticks: holds without ticks
        wb(1'b1, WT, 8'h82);
        tx_done <= 1'b1;
        @(posedge mclk);
        tx_done <= 1'b0;
        repeat (60) @(posedge mclk);
        chk("ignore held", 11'h1, {10'h0, receive_ignore});
        card.pulse(1);
        card.pulse(1);
        repeat (3) @(posedge mclk);
        chk("ignore ended", 11'h0, {10'h0, receive_ignore});
        repeat (5) @(posedge mclk);
        for (int k = 0; k < 5; k++) chk("missing pulses", 11'h0, 11'(evq[k].size()));
        chk("missing reads", 11'h0, 11'(rdq.size()));
        tally_and_finish();
    end
endmodule : testbench
